//--- logic/lpsr_consts.vh
// constants for the lin transceiver status and routing block
`ifndef LPSR_CONSTS_VH
`define LPSR_CONSTS_VH

// -----------------------------------------------------------------
// bus geometry
// -----------------------------------------------------------------
`define LPSR_ADDR_W 12
`define LPSR_DATA_W 32
`define LPSR_RESP_OKAY 2'h0
`define LPSR_RESP_SLVERR 2'h2

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define LPSR_IDX_CONTROL 10'h050
`define LPSR_IDX_FAULT 10'h052
`define LPSR_IDX_LINE 10'h053
`define LPSR_IDX_TX_ROUTE 10'h054
`define LPSR_IDX_RX_ROUTE 10'h055
`define LPSR_IDX_IRQ_STATUS 10'h058
`define LPSR_IDX_IRQ_CLEAR 10'h059
`define LPSR_IDX_IRQ_ENABLE 10'h05A

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define LPSR_BIT_OVERTEMP 7
`define LPSR_BIT_RF_DISTURB 5
`define LPSR_BIT_UNDERVOLT 3
`define LPSR_BIT_TX_READY 7
`define LPSR_BIT_RX_LEVEL 1
`define LPSR_BIT_TX_LEVEL 0
`define LPSR_BIT_SRC_PORT_B 1
`define LPSR_BIT_SRC_UART 0
`define LPSR_BIT_DST_PORT_B 1
`define LPSR_BIT_DST_UART 0
`define LPSR_BIT_TX_DIRECT 4
`define LPSR_FAULT_MASK 8'hA8

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define LPSR_RST_CONTROL 8'h00
`define LPSR_RST_FAULT 8'h00
`define LPSR_RST_TX_ROUTE 8'h00
`define LPSR_RST_RX_ROUTE 8'h00
`define LPSR_RST_IRQ 8'h00

`endif

//--- logic/lpsr_lin_status_routing.v
// lin transceiver status flags, line routing and axi4-lite registers
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "lpsr_consts.vh"
// -----------------------------------------------------------------
// -----------------------------------------------------------------
module lpsr_lin_status_routing (
    input wire aclk,
    input wire aresetn,
    input wire [`LPSR_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [`LPSR_DATA_W-1:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`LPSR_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [`LPSR_DATA_W-1:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire overtemp_in,
    input wire rf_disturb_in,
    input wire undervolt_in,
    input wire tx_ready_in,
    input wire rx_dominant_in,
    input wire uart_tx_dominant,
    input wire port_b_tx_dominant,
    output reg lin_tx_dominant,
    output reg uart_rx_dominant,
    output reg port_b_rx_dominant,
    output reg irq
);

// -----------------------------------------------------------------
// input synchronisers
// -----------------------------------------------------------------
reg [4:0] pin_meta;
reg [4:0] pin_sync;

always @(posedge aclk) begin
    if (!aresetn) begin
        pin_meta <= 5'h00;
        pin_sync <= 5'h00;
    end else begin
        pin_meta <= {rx_dominant_in, tx_ready_in, undervolt_in,
            rf_disturb_in, overtemp_in};
        pin_sync <= pin_meta;
    end
end

wire overtemp_seen = pin_sync[0];
wire rf_disturb_seen = pin_sync[1];
wire undervolt_seen = pin_sync[2];
wire tx_ready_seen = pin_sync[3];
wire rx_dominant_seen = pin_sync[4];

// -----------------------------------------------------------------
// registers
// -----------------------------------------------------------------
reg [7:0] lin_control;
reg [7:0] lin_fault_status;
reg [7:0] lin_transmit_routing;
reg [7:0] lin_receive_routing;
reg [7:0] irq_status;
reg [7:0] irq_enable;
reg [2:0] fault_prev;

// -----------------------------------------------------------------
// write channel
// -----------------------------------------------------------------
reg aw_held;
reg w_held;
reg [`LPSR_ADDR_W-1:0] wr_addr;
reg [7:0] wr_byte;
reg wr_lane0;

wire aw_take = s_axi_awvalid && s_axi_awready;
wire w_take = s_axi_wvalid && s_axi_wready;
wire wr_go = aw_held && w_held && !s_axi_bvalid;
wire [9:0] wr_idx = wr_addr[`LPSR_ADDR_W-1:2];
wire wr_aligned = (wr_addr[1:0] == 2'h0);

reg wr_known;

always @* begin
    case (wr_idx)
        `LPSR_IDX_CONTROL, `LPSR_IDX_FAULT, `LPSR_IDX_LINE,
        `LPSR_IDX_TX_ROUTE, `LPSR_IDX_RX_ROUTE,
        `LPSR_IDX_IRQ_STATUS, `LPSR_IDX_IRQ_CLEAR,
        `LPSR_IDX_IRQ_ENABLE: wr_known = wr_aligned;
        default: wr_known = 1'b0;
    endcase
end

wire wr_en = wr_go && wr_known && wr_lane0;

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `LPSR_RESP_OKAY;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        wr_addr <= {`LPSR_ADDR_W{1'b0}};
        wr_byte <= 8'h00;
        wr_lane0 <= 1'b0;
    end else begin
        if (aw_take) begin
            aw_held <= 1'b1;
            wr_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (w_take) begin
            w_held <= 1'b1;
            wr_byte <= s_axi_wdata[7:0];
            wr_lane0 <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end
        if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `LPSR_RESP_OKAY
                : `LPSR_RESP_SLVERR;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// -----------------------------------------------------------------
// control and routing registers
// -----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        lin_control <= `LPSR_RST_CONTROL;
        lin_transmit_routing <= `LPSR_RST_TX_ROUTE;
        lin_receive_routing <= `LPSR_RST_RX_ROUTE;
        irq_enable <= `LPSR_RST_IRQ;
    end else if (wr_en) begin
        case (wr_idx)
            `LPSR_IDX_CONTROL: begin
                lin_control <= wr_byte & 8'h10;
            end
            `LPSR_IDX_TX_ROUTE: begin
                lin_transmit_routing <= wr_byte & 8'h03;
            end
            `LPSR_IDX_RX_ROUTE: begin
                lin_receive_routing <= wr_byte & 8'h03;
            end
            `LPSR_IDX_IRQ_ENABLE: begin
                irq_enable <= wr_byte & `LPSR_FAULT_MASK;
            end
            default: begin
                lin_control <= lin_control;
            end
        endcase
    end
end

// -----------------------------------------------------------------
// sticky fault flags and interrupt status
// -----------------------------------------------------------------
reg [7:0] fault_set;
reg [7:0] fault_clr;
reg [7:0] irq_set;
reg [7:0] irq_clr;

always @* begin
    fault_set = 8'h00;
    fault_set[`LPSR_BIT_OVERTEMP] = overtemp_seen;
    fault_set[`LPSR_BIT_RF_DISTURB] = rf_disturb_seen;
    fault_set[`LPSR_BIT_UNDERVOLT] = undervolt_seen;
    irq_set = fault_set & ~{fault_prev[0], 1'b0, fault_prev[1],
        1'b0, fault_prev[2], 3'h0};
    fault_clr = 8'h00;
    irq_clr = 8'h00;
    if (wr_en && wr_idx == `LPSR_IDX_FAULT) begin
        fault_clr = wr_byte & `LPSR_FAULT_MASK;
    end
    if (wr_en && wr_idx == `LPSR_IDX_IRQ_CLEAR) begin
        irq_clr = wr_byte & `LPSR_FAULT_MASK;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        lin_fault_status <= `LPSR_RST_FAULT;
        irq_status <= `LPSR_RST_IRQ;
        fault_prev <= 3'h0;
    end else begin
        fault_prev <= {undervolt_seen, rf_disturb_seen, overtemp_seen};
        lin_fault_status <= (lin_fault_status & ~fault_clr)
            | fault_set;
        irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
end

// -----------------------------------------------------------------
// line routing
// -----------------------------------------------------------------
reg tx_selected;

always @* begin
    if (lin_transmit_routing[`LPSR_BIT_SRC_UART]) begin
        tx_selected = uart_tx_dominant;
    end else if (lin_transmit_routing[`LPSR_BIT_SRC_PORT_B]) begin
        tx_selected = port_b_tx_dominant;
    end else begin
        tx_selected = 1'b0;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        lin_tx_dominant <= 1'b0;
        uart_rx_dominant <= 1'b0;
        port_b_rx_dominant <= 1'b0;
        irq <= 1'b0;
    end else begin
        lin_tx_dominant <= tx_selected
            | lin_control[`LPSR_BIT_TX_DIRECT];
        uart_rx_dominant <= rx_dominant_seen
            & lin_receive_routing[`LPSR_BIT_DST_UART];
        port_b_rx_dominant <= rx_dominant_seen
            & lin_receive_routing[`LPSR_BIT_DST_PORT_B];
        irq <= |((irq_status | irq_set) & irq_enable);
    end
end

// -----------------------------------------------------------------
// read channel
// -----------------------------------------------------------------
wire [9:0] rd_idx = s_axi_araddr[`LPSR_ADDR_W-1:2];
wire rd_aligned = (s_axi_araddr[1:0] == 2'h0);
reg [7:0] rd_byte;
reg rd_known;
reg [7:0] line_status;

always @* begin
    line_status = 8'h00;
    line_status[`LPSR_BIT_TX_READY] = tx_ready_seen;
    line_status[`LPSR_BIT_RX_LEVEL] = rx_dominant_seen;
    line_status[`LPSR_BIT_TX_LEVEL] = lin_tx_dominant;
    rd_known = rd_aligned;
    case (rd_idx)
        `LPSR_IDX_CONTROL: rd_byte = lin_control;
        `LPSR_IDX_FAULT: rd_byte = lin_fault_status;
        `LPSR_IDX_LINE: rd_byte = line_status;
        `LPSR_IDX_TX_ROUTE: rd_byte = lin_transmit_routing;
        `LPSR_IDX_RX_ROUTE: rd_byte = lin_receive_routing;
        `LPSR_IDX_IRQ_STATUS: rd_byte = irq_status;
        `LPSR_IDX_IRQ_CLEAR: rd_byte = 8'h00;
        `LPSR_IDX_IRQ_ENABLE: rd_byte = irq_enable;
        default: begin
            rd_byte = 8'h00;
            rd_known = 1'b0;
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= {`LPSR_DATA_W{1'b0}};
        s_axi_rresp <= `LPSR_RESP_OKAY;
    end else begin
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_known ? rd_byte : 8'h00};
            s_axi_rresp <= rd_known ? `LPSR_RESP_OKAY
                : `LPSR_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule // lpsr_lin_status_routing

//--- testbench/lpsr_chk.sv
// bus and receive path checker for the lin status and routing block
`timescale 1ns/1ps
module lpsr_chk (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire rx_dominant_in,
    input wire uart_rx_dominant,
    input wire port_b_rx_dominant
);
    // ------------------------------------------------
    // handshake and path properties
    // ------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("write response dropped");
    write_busy_a: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write not refused");
    read_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data missing");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid) else $error("read data dropped");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read not refused");
    uart_rx_path_a: assert property (uart_rx_dominant |->
        $past(rx_dominant_in, 3)) else $error("uart rx without line");
    port_rx_path_a: assert property (port_b_rx_dominant |->
        $past(rx_dominant_in, 3)) else $error("port b rx without line");
    reset_idle_a: assert property ($rose(aresetn) |->
        s_axi_awready && s_axi_arready && !s_axi_bvalid && !s_axi_rvalid
        && !uart_rx_dominant && !port_b_rx_dominant)
        else $error("outputs not idle after reset");
endmodule // lpsr_chk
bind lpsr_lin_status_routing lpsr_chk u_lpsr_chk (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_dominant_in(rx_dominant_in),
    .uart_rx_dominant(uart_rx_dominant),
    .port_b_rx_dominant(port_b_rx_dominant)
);

//--- testbench/lpsr_line_model.sv
// transceiver line and port side partner for the lin status block
`timescale 1ns/1ps
module lpsr_line_model (
    input wire lin_tx_dominant,
    input wire [6:0] req,
    output wire overtemp_in,
    output wire rf_disturb_in,
    output wire undervolt_in,
    output wire tx_ready_in,
    output wire rx_dominant_in,
    output wire uart_tx_dominant,
    output wire port_b_tx_dominant
);
    assign {overtemp_in, rf_disturb_in, undervolt_in} = req[6:4];
    assign tx_ready_in = req[3];
    // wired bus: any node driving dominant wins
    assign rx_dominant_in = req[2] | lin_tx_dominant;
    assign {uart_tx_dominant, port_b_tx_dominant} = req[1:0];
endmodule // lpsr_line_model

//--- testbench/lpsr_lin_status_routing_test.sv
// self-checking bench for the lin status and routing block
`timescale 1ns/1ps
`include "lpsr_consts.vh"
module lpsr_lin_status_routing_test;
    localparam [11:0] A_CTL = {`LPSR_IDX_CONTROL, 2'h0},
        A_FLT = {`LPSR_IDX_FAULT, 2'h0}, A_LIN = {`LPSR_IDX_LINE, 2'h0},
        A_TXR = {`LPSR_IDX_TX_ROUTE, 2'h0},
        A_RXR = {`LPSR_IDX_RX_ROUTE, 2'h0},
        A_IST = {`LPSR_IDX_IRQ_STATUS, 2'h0},
        A_ICL = {`LPSR_IDX_IRQ_CLEAR, 2'h0},
        A_IEN = {`LPSR_IDX_IRQ_ENABLE, 2'h0};
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, m;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bexp = 2'h0;
    logic [6:0] req = 7'h0;
    logic [5:0] t;
    logic [5:0] tx_tab[9] = '{6'h06, 6'h0D, 6'h0A, 6'h13, 6'h14, 6'h1A,
        6'h1F, 6'h21, 6'h31};
    logic [11:0] z[6] = '{A_CTL, A_FLT, A_LIN, A_TXR, A_RXR, A_IEN};
    wire awready, wready, bvalid, arready, rvalid, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire ovt, rf, unv, rdy, rxd, utx, ptx, ltx, urx, prx;
    int bad_count = 0, check_count = 0, i;
    always #4 aclk = ~aclk;
    lpsr_lin_status_routing u_lpsr_lin_status_routing (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .overtemp_in(ovt), .rf_disturb_in(rf),
        .undervolt_in(unv), .tx_ready_in(rdy), .rx_dominant_in(rxd),
        .uart_tx_dominant(utx), .port_b_tx_dominant(ptx),
        .lin_tx_dominant(ltx), .uart_rx_dominant(urx),
        .port_b_rx_dominant(prx), .irq(irq));
    lpsr_line_model u_lpsr_line_model (
        .lin_tx_dominant(ltx), .req(req), .overtemp_in(ovt),
        .rf_disturb_in(rf), .undervolt_in(unv), .tx_ready_in(rdy),
        .rx_dominant_in(rxd), .uart_tx_dominant(utx),
        .port_b_tx_dominant(ptx));
    // ------------------------------------------------
    // bus tasks
    // ------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        chk("bresp", {30'h0, bexp}, {30'h0, bresp});
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rready <= 1'h0;
        chk("rdata", e, rdata);
        chk("rresp", {30'h0, r}, {30'h0, rresp});
    endtask
    task report_and_stop;
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        tick(3);
        aresetn <= 1'h1;
        foreach (z[k]) rd(z[k], 32'h0, 2'h0);
        rd(12'h158, 32'h0, 2'h2);
        bexp = 2'h2;
        wr(12'h156, 32'h3);
        bexp = 2'h0;
        wstrb <= 4'hE;
        wr(A_RXR, 32'h3);
        wstrb <= 4'hF;
        rd(A_RXR, 32'h0, 2'h0);
        wr(A_IEN, 32'h80);
        for (i = 0; i < 3; i++) begin
            m = 32'h1 << (7 - 2 * i);
            req[6 - i] <= 1'h1;
            tick(3);
            req[6 - i] <= 1'h0;
            tick(5);
            rd(A_FLT, m, 2'h0);
            rd(A_IST, m, 2'h0);
            chk("irq", {31'h0, i == 0}, {31'h0, irq});
            wr(A_FLT, 32'h0);
            rd(A_FLT, m, 2'h0);
            wr(A_FLT, m);
            rd(A_FLT, 32'h0, 2'h0);
            wr(A_ICL, 32'hA8);
            tick(2);
            chk("irq", 32'h0, {31'h0, irq});
        end
        req[6:4] <= 3'h7;
        tick(5);
        wr(A_FLT, 32'hA8);
        rd(A_FLT, 32'hA8, 2'h0);
        req[6:4] <= 3'h0;
        tick(5);
        wr(A_FLT, 32'hA8);
        rd(A_FLT, 32'h0, 2'h0);
        wr(A_ICL, 32'hA8);
        req[3] <= 1'h1;
        tick(5);
        rd(A_LIN, 32'h80, 2'h0);
        req[2] <= 1'h1;
        tick(5);
        rd(A_LIN, 32'h82, 2'h0);
        req[2] <= 1'h0;
        wr(A_CTL, 32'h10);
        tick(5);
        rd(A_LIN, 32'h83, 2'h0);
        foreach (tx_tab[k]) begin
            t = tx_tab[k];
            wr(A_CTL, {27'h0, t[5], 4'h0});
            wr(A_TXR, {30'h0, t[4:3]});
            req[1:0] <= t[2:1];
            tick(3);
            chk("lin_tx", t[0], ltx);
        end
        wr(A_CTL, 32'h0);
        req[2] <= 1'h1;
        for (i = 0; i < 4; i++) begin
            wr(A_RXR, i);
            rd(A_RXR, i, 2'h0);
            tick(5);
            chk("uart_rx", {31'h0, i[0]}, {31'h0, urx});
            chk("port_b_rx", {31'h0, i[1]}, {31'h0, prx});
        end
        req[2] <= 1'h0;
        tick(5);
        chk("port_b_rx", 32'h0, {31'h0, prx});
        req[2] <= 1'h1;
        aresetn <= 1'h0;
        tick(3);
        aresetn <= 1'h1;
        tick(5);
        chk("uart_rx", 32'h0, {31'h0, urx});
        chk("port_b_rx", 32'h0, {31'h0, prx});
        rd(A_RXR, 32'h0, 2'h0);
        report_and_stop;
    end
    initial begin
        tick(20000);
        bad_count++;
        report_and_stop;
    end
endmodule // lpsr_lin_status_routing_test
